// >>> common/codec_regs_pkg.sv
package codec_regs_pkg;
   // Register offsets on the control port.
   localparam logic [7:0] DETECT_OFS = 8'h0e;
   localparam logic [7:0] LGAIN_OFS = 8'h0f;
   localparam logic [7:0] RGAIN_OFS = 8'h10;
   localparam logic [7:0] MIC_L_OFS = 8'h11;
   localparam logic [7:0] MIC_R_OFS = 8'h12;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h20;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h21;
   // Field positions in the detection register.
   localparam int COUPLE_BIT = 7;
   localparam int FULL_DIFF_BIT = 6;
   localparam int BTN_BIT = 5;
   localparam int HS_BIT = 4;
   localparam int PSEUDO_BIT = 3;
   // Field positions in the gain and mixer registers.
   localparam int MUTE_BIT = 7;
   localparam int GAIN_MSB = 6;
   localparam int MIX_HI_LSB = 4;
   // Reset values.
   localparam logic [7:0] GAIN_RST = 8'h80;
   localparam logic [7:0] MIX_RST = 8'hff;
   localparam logic [7:0] RDATA_RST = 8'h00;
   localparam logic [1:0] IRQ_RST = 2'h0;
   // Gain saturates at code 119, which is 59.5 dB.
   localparam logic [6:0] GAIN_MAX = 7'h77;
   // Mixer level codes: 0 to 8 attenuate in 1.5 dB steps, 15 disconnects.
   localparam logic [3:0] MIX_MAX_ATTEN = 4'h8;
   localparam logic [3:0] MIX_OFF = 4'hf;
   // Interrupt status bits.
   localparam int IRQ_BTN = 0;
   localparam int IRQ_HS = 1;
   // Mixer paths: 0 left mic to left, 1 right mic to left, 2 left to right, 3 right to right.
   localparam int N_PATHS = 4;

   typedef struct packed {
      logic [7:0] addr;  // Register offset.
      logic [7:0] wdata; // Write data.
      logic wr;          // Write strobe.
      logic rd;          // Read strobe.
   } reg_req_type;

   typedef struct packed {
      logic connect;    // Input joins the mixer.
      logic [3:0] atten; // Attenuation in 1.5 dB steps.
   } mic_route_type;

   typedef struct packed {
      logic ac_coupled;  // High-power outputs ac-coupled.
      logic full_diff;   // Fully differential outputs in use.
      logic pseudo_diff; // Pseudodifferential outputs in use.
      logic left_mute;   // Left gain stage muted.
      logic right_mute;  // Right gain stage muted.
      logic [6:0] left_gain;  // Left gain in 0.5 dB steps.
      logic [6:0] right_gain; // Right gain in 0.5 dB steps.
      mic_route_type [N_PATHS-1:0] mic; // Mixer paths.
   } analog_ctrl_type;
endpackage

// >>> src/bit_sync.sv
// Two-flop synchroniser, one pair of flops per bit.
module bit_sync #(
   parameter int W = 2 // Number of bits.
) (
   input wire logic sys_clk,       // System clock.
   input wire logic rstn,          // Asynchronous reset, active low.
   input wire logic [W-1:0] async_in, // Pins from outside.
   output logic [W-1:0] sync_out   // Synchronised levels.
);
   logic [W-1:0] meta_q; // First stage; only the second stage reads it.

   // Each bit gets its own pair of flops.
   for (genvar gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge sys_clk or negedge rstn) begin
         if (!rstn) begin
            meta_q[gi] <= 1'b0;
            sync_out[gi] <= 1'b0;
         end else begin
            meta_q[gi] <= async_in[gi];
            sync_out[gi] <= meta_q[gi];
         end
      end
   end
endmodule // bit_sync

// >>> src/codec_adc_input_headset_regs.sv
// Local design decision: the address-and-strobe port.
module codec_adc_input_headset_regs
   import codec_regs_pkg::*;
(
   input wire logic sys_clk,                    // 10 MHz system clock.
   input wire logic rstn,                       // Asynchronous reset, active low.
   input codec_regs_pkg::reg_req_type req,      // Register request.
   output logic [7:0] rd_data,                  // Read data, one cycle after the strobe.
   output logic irq,                            // Level interrupt.
   input wire logic button_pressed,             // Debounced button press level, from outside.
   input wire logic headset_present,            // Debounced headset level, from outside.
   output codec_regs_pkg::analog_ctrl_type ctrl // Settings for the analog path.
);
   import codec_regs_pkg::*;

   // All state of the block but the synchroniser flops in one record.
   typedef struct packed {
      logic couple;       // Driver coupling bit.
      logic full_diff;    // Fully differential bit.
      logic pseudo;       // Pseudodifferential bit.
      logic btn_flag;     // Sticky button flag.
      logic btn_prev;     // Button level one cycle ago.
      logic hs_prev;      // Headset level one cycle ago.
      logic [7:0] lgain;  // Left gain register.
      logic [7:0] rgain;  // Right gain register.
      logic [7:0] mic_l;  // Mic paths into the left mixer.
      logic [7:0] mic_r;  // Mic paths into the right mixer.
      logic [1:0] irq_stat; // Sticky interrupt status.
      logic [1:0] irq_mask; // Interrupt mask.
      logic [7:0] rdata;  // Registered read data.
      logic [6:0] lgain_eff; // Saturated left gain.
      logic [6:0] rgain_eff; // Saturated right gain.
      mic_route_type [N_PATHS-1:0] mic; // Decoded mixer paths.
   } state_type;

   state_type st_q; // Registered state.
   state_type st_d; // Next state.

   logic [1:0] pin_sync; // Synchronised button and headset levels.
   logic btn_sync;       // Synchronised button level.
   logic hs_sync;        // Synchronised headset level.
   logic btn_rise;       // One-cycle pulse on a new press.
   logic hs_change;      // One-cycle pulse on plug or unplug.
   logic rd_detect;      // Read of the detection register.
   logic [7:0] detect_word; // Detection register as software sees it.
   logic [15:0] mix_codes;  // Both mixer registers side by side.
   mic_route_type [N_PATHS-1:0] route; // Decoded paths from the registers.

   // Both detector levels come from another domain, so they pass two flops.
   bit_sync #(
      .W(2)
   ) u_pin_sync (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .async_in({headset_present, button_pressed}),
      .sync_out(pin_sync)
   );

   assign btn_sync = pin_sync[0];
   assign hs_sync = pin_sync[1];

   // Edges are taken from the second sync stage and a stored copy.
   assign btn_rise = btn_sync & ~st_q.btn_prev;
   assign hs_change = hs_sync ^ st_q.hs_prev;

   // A detection read is the event that clears the button flag.
   assign rd_detect = req.rd && (req.addr == DETECT_OFS);

   // The headset bit is the live level, never a stored copy.
   // Reserved low bits always read as zero.
   assign detect_word = {st_q.couple, st_q.full_diff, st_q.btn_flag, hs_sync, st_q.pseudo, 3'h0};

   // The four mixer fields, high nibble of the left register first.
   assign mix_codes = {st_q.mic_l, st_q.mic_r};

   // One decoder per mixer path.
   for (genvar gi = 0; gi < N_PATHS; gi++) begin : g_path
      mix_level_decode u_dec (
         .code(mix_codes[15-4*gi -: 4]),
         .route(route[gi])
      );
   end

   // Clamps a gain code; codes above 119 all give 59.5 dB.
   function automatic logic [6:0] gain_sat(input logic [6:0] code);
      gain_sat = (code > GAIN_MAX) ? GAIN_MAX : code;
   endfunction

   // Next-state logic: reads, writes, events and decoding.
   always_comb begin
      st_d = st_q;
      st_d.btn_prev = btn_sync;
      st_d.hs_prev = hs_sync;
      // Read data stand for one cycle only.
      st_d.rdata = RDATA_RST;

      // Read mux; unmapped offsets read as zero.
      if (req.rd) begin
         case (req.addr)
            DETECT_OFS: begin
               st_d.rdata = detect_word;
            end
            LGAIN_OFS: begin
               st_d.rdata = st_q.lgain;
            end
            RGAIN_OFS: begin
               st_d.rdata = st_q.rgain;
            end
            MIC_L_OFS: begin
               st_d.rdata = st_q.mic_l;
            end
            MIC_R_OFS: begin
               st_d.rdata = st_q.mic_r;
            end
            IRQ_STAT_OFS: begin
               st_d.rdata = {6'h00, st_q.irq_stat};
            end
            IRQ_MASK_OFS: begin
               st_d.rdata = {6'h00, st_q.irq_mask};
            end
            default: begin
               st_d.rdata = RDATA_RST;
            end
         endcase
      end

      // Reading the detection register clears the button flag.
      if (rd_detect) begin
         st_d.btn_flag = 1'b0;
      end
      // A press in the same cycle still sets it, so none is lost.
      if (btn_rise) begin
         st_d.btn_flag = 1'b1;
      end

      // Writes; unmapped offsets are ignored.
      if (req.wr) begin
         case (req.addr)
            DETECT_OFS: begin
               // Only the three writable bits take the data.
               st_d.couple = req.wdata[COUPLE_BIT];
               st_d.full_diff = req.wdata[FULL_DIFF_BIT];
               st_d.pseudo = req.wdata[PSEUDO_BIT];
               // The flag, headset and reserved bits keep their value.
            end
            LGAIN_OFS: begin
               st_d.lgain = req.wdata;
            end
            RGAIN_OFS: begin
               st_d.rgain = req.wdata;
            end
            MIC_L_OFS: begin
               st_d.mic_l = req.wdata;
            end
            MIC_R_OFS: begin
               st_d.mic_r = req.wdata;
            end
            IRQ_STAT_OFS: begin
               // Writing a one clears that status bit.
               st_d.irq_stat = st_q.irq_stat & ~req.wdata[1:0];
            end
            IRQ_MASK_OFS: begin
               st_d.irq_mask = req.wdata[1:0];
            end
            default: begin
               st_d.couple = st_q.couple;
            end
         endcase
      end

      // Events set status after the clear, so a set wins.
      if (btn_rise) begin
         st_d.irq_stat[IRQ_BTN] = 1'b1;
      end
      if (hs_change) begin
         st_d.irq_stat[IRQ_HS] = 1'b1;
      end

      // Decoded settings lag the registers by one cycle.
      // This keeps the analog controls glitch free.
      st_d.lgain_eff = gain_sat(st_q.lgain[GAIN_MSB:0]);
      st_d.rgain_eff = gain_sat(st_q.rgain[GAIN_MSB:0]);
      st_d.mic = route;
   end

   // State register; reset leaves gain stages muted and mics off.
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= '0;
         st_q.lgain <= GAIN_RST;
         st_q.rgain <= GAIN_RST;
         st_q.mic_l <= MIX_RST;
         st_q.mic_r <= MIX_RST;
         st_q.irq_stat <= IRQ_RST;
         st_q.irq_mask <= IRQ_RST;
         st_q.rdata <= RDATA_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // All outputs but irq come straight from flops; irq gates the status flops with the mask.
   assign rd_data = st_q.rdata;
   assign irq = |(st_q.irq_stat & st_q.irq_mask);
   // Software keeps the two differential bits exclusive; both are passed on.
   assign ctrl.ac_coupled = st_q.couple;
   assign ctrl.full_diff = st_q.full_diff;
   assign ctrl.pseudo_diff = st_q.pseudo;
   assign ctrl.left_mute = st_q.lgain[MUTE_BIT];
   assign ctrl.right_mute = st_q.rgain[MUTE_BIT];
   assign ctrl.left_gain = st_q.lgain_eff;
   assign ctrl.right_gain = st_q.rgain_eff;
   assign ctrl.mic = st_q.mic;

   // Checks on the block's own behaviour.
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   // A write to one of the gain, mixer or detection registers.
   sequence s_wr_lgain;
      req.wr && req.addr == LGAIN_OFS;
   endsequence

   sequence s_wr_rgain;
      req.wr && req.addr == RGAIN_OFS;
   endsequence

   sequence s_wr_mic_l;
      req.wr && req.addr == MIC_L_OFS;
   endsequence

   sequence s_wr_mic_r;
      req.wr && req.addr == MIC_R_OFS;
   endsequence

   sequence s_wr_detect;
      req.wr && req.addr == DETECT_OFS;
   endsequence

   // A press sets the flag at the next edge.
   AST_BTN_LATCH: assert property (btn_rise |=> st_q.btn_flag)
      else $error("button flag not set after a press");

   // The flag holds while nobody reads, even after release.
   AST_BTN_HOLD: assert property (st_q.btn_flag && !rd_detect |=> st_q.btn_flag)
      else $error("button flag dropped without a read");

   // A read returns the flag and then clears it.
   AST_RD_CLEAR: assert property (rd_detect && !btn_rise |=>
      (rd_data[BTN_BIT] == $past(st_q.btn_flag)) && !st_q.btn_flag)
      else $error("detection read did not return and clear the flag");

   // The headset bit reads the live level.
   AST_HEADSET: assert property (rd_detect |=> rd_data[HS_BIT] == $past(hs_sync))
      else $error("headset bit does not follow the input");

   // Reserved bits read zero and ignore writes.
   AST_RSVD: assert property (rd_detect |=> rd_data[2:0] == 3'h0)
      else $error("reserved detection bits not zero");

   // Writes steer the coupling and both differential outputs.
   AST_DRIVER: assert property (s_wr_detect |=>
      ctrl.ac_coupled == $past(req.wdata[COUPLE_BIT]) &&
      ctrl.full_diff == $past(req.wdata[FULL_DIFF_BIT]) &&
      ctrl.pseudo_diff == $past(req.wdata[PSEUDO_BIT]))
      else $error("driver setting did not follow the write");

   // Mute follows the written bit.
   AST_MUTE: assert property (s_wr_lgain |=> ctrl.left_mute == $past(req.wdata[MUTE_BIT]))
      else $error("left mute did not follow the write");

   // Right mute follows the written bit.
   AST_RMUTE: assert property (s_wr_rgain |=> ctrl.right_mute == $past(req.wdata[MUTE_BIT]))
      else $error("right mute did not follow the write");

   // Right gain saturates two cycles after the write.
   AST_RGAIN: assert property (s_wr_rgain ##1 !(req.wr && req.addr == RGAIN_OFS) |=>
      ctrl.right_gain == (($past(req.wdata[GAIN_MSB:0], 2) > GAIN_MAX) ? GAIN_MAX : $past(req.wdata[GAIN_MSB:0], 2)))
      else $error("right gain mapping wrong");

   // Left gain follows the written code and never exceeds 59.5 dB.
   AST_LGAIN_MAX: assert property (s_wr_lgain ##1 !(req.wr && req.addr == LGAIN_OFS) |=>
      ctrl.left_gain == (($past(req.wdata[GAIN_MSB:0], 2) > GAIN_MAX) ? GAIN_MAX : $past(req.wdata[GAIN_MSB:0], 2)))
      else $error("left gain mapping wrong");

   // A valid code connects the path with that attenuation.
   AST_MIX_ON: assert property (s_wr_mic_l ##0 req.wdata[7:4] <= MIX_MAX_ATTEN
      ##1 !(req.wr && req.addr == MIC_L_OFS) |=>
      ctrl.mic[0].connect && ctrl.mic[0].atten == $past(req.wdata[7:4], 2))
      else $error("mic path not connected by a valid code");

   // Code 1111 leaves the path off.
   AST_MIX_OFF: assert property (s_wr_mic_l ##0 req.wdata[3:0] == MIX_OFF
      ##1 !(req.wr && req.addr == MIC_L_OFS) |=> !ctrl.mic[1].connect)
      else $error("mic path connected by the off code");

   // The interrupt is high once the button status bit rises while that bit is unmasked.
   AST_IRQ: assert property ($rose(st_q.irq_stat[IRQ_BTN]) && st_q.irq_mask[IRQ_BTN] |-> irq)
      else $error("interrupt missing for a masked-in event");

   // A valid code joins the right mic to the right mixer at that level.
   AST_MIX_ON_R: assert property (s_wr_mic_r ##0 req.wdata[3:0] <= MIX_MAX_ATTEN
      ##1 !(req.wr && req.addr == MIC_R_OFS) |=>
      ctrl.mic[3].connect && ctrl.mic[3].atten == $past(req.wdata[3:0], 2))
      else $error("right mic path not connected by a valid code");

   // A press sets its status bit even beside a clearing write, so no event is lost.
   AST_BTN_STAT: assert property (btn_rise |=> st_q.irq_stat[IRQ_BTN])
      else $error("button status bit not set");

   // A plug or unplug sets its status bit even beside a clearing write.
   AST_HS_STAT: assert property (hs_change |=> st_q.irq_stat[IRQ_HS])
      else $error("headset status bit not set");

   // A detection write leaves the sticky flag alone.
   AST_DETECT_HOLD: assert property (s_wr_detect ##0 !btn_rise |=> st_q.btn_flag == $past(st_q.btn_flag))
      else $error("detection write changed the button flag");

   // Read data fall back to zero in any cycle that follows no read.
   AST_RDATA_IDLE: assert property (!req.rd |=> rd_data == RDATA_RST)
      else $error("read data stood longer than one cycle");
endmodule // codec_adc_input_headset_regs

// >>> src/mix_level_decode.sv
// Turns a 4-bit mixer level code into a connect flag and attenuation.
module mix_level_decode
   import codec_regs_pkg::*;
(
   input wire logic [3:0] code,                // Level code from a register.
   output codec_regs_pkg::mic_route_type route // Decoded path setting.
);
   // Codes 0 to 8 connect; 15 and the reserved codes leave the input off.
   // Reserved codes are treated as off so a bad write cannot add noise.
   always_comb begin
      route.connect = (code <= MIX_MAX_ATTEN);
      route.atten = route.connect ? code : 4'h0;
   end
endmodule // mix_level_decode

// >>> tb/codec_adc_input_headset_regs_tb.sv
// Self-checking bench for the audio input and headset register bank.
module codec_adc_input_headset_regs_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import codec_regs_pkg::*;

   logic sys_clk; // Bench clock, 10 MHz.
   logic rstn; // Reset, active low.
   reg_req_type req; // Register request driven by the bench.
   logic [7:0] rd_data; // Read data from the block.
   logic irq; // Level interrupt from the block.
   logic button_pressed; // Button level fed to the block.
   logic headset_present; // Headset level fed to the block.
   analog_ctrl_type ctrl; // Analog settings from the block.
   int failures; // Mismatches seen.
   int samples_checked; // Comparisons made.
   int cycles; // Clock cycles since time zero.
   logic [31:0] rng_q; // Xorshift state.
   logic [7:0] rv; // Value returned by a read.
   logic [3:0] legal[10]; // Mixer codes that software may write.

   codec_adc_input_headset_regs u_codec_adc_input_headset_regs (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .req(req),
      .rd_data(rd_data),
      .irq(irq),
      .button_pressed(button_pressed),
      .headset_present(headset_present),
      .ctrl(ctrl)
   );

   // The clock toggles every half period of 50 ns.
   always #50 sys_clk = ~sys_clk;

   // A hung sequence is cut short well past the expected run length of about 550 cycles.
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end

   // Xorshift generator, so every run draws the same values.
   function automatic logic [31:0] next_rand();
      rng_q = rng_q ^ (rng_q << 13);
      rng_q = rng_q ^ (rng_q >> 17);
      rng_q = rng_q ^ (rng_q << 5);
      return rng_q;
   endfunction

   // Gain codes above the top step saturate at 59.5 dB.
   function automatic logic [6:0] gain_exp(input logic [6:0] c);
      return (c > 7'h77) ? 7'h77 : c;
   endfunction

   // Codes up to eight connect the input with that many 1.5 dB steps; the off code disconnects.
   function automatic logic [4:0] route_exp(input logic [3:0] c);
      return (c <= 4'h8) ? {1'b1, c} : 5'h00;
   endfunction

   // Compares with case equality so an unknown never passes as a match.
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One-cycle write strobe; the strobe drops at the edge that takes it.
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask

   // One-cycle read strobe; the data stand only in the cycle after the strobe is taken.
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1 d = rd_data;
   endtask

   // Reads a register and compares the whole byte.
   task automatic rd_check(input string name, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd_reg(a, d);
      check(name, d, exp);
   endtask

   // Lets the registered outputs settle after a write.
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      #1;
   endtask

   // Writes a gain register, reads it back and checks the mute and saturated gain outputs.
   task automatic gain_case(input logic right, input logic [7:0] v);
      wr_reg(right ? RGAIN_OFS : LGAIN_OFS, v);
      rd_check("gain_reg", right ? RGAIN_OFS : LGAIN_OFS, v);
      settle();
      if (right) begin
         check("right_mute", ctrl.right_mute, v[7]);
         check("right_gain", ctrl.right_gain, gain_exp(v[6:0]));
      end else begin
         check("left_mute", ctrl.left_mute, v[7]);
         check("left_gain", ctrl.left_gain, gain_exp(v[6:0]));
      end
   endtask

   // Prints the counts and the verdict, then stops the run.
   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      logic [7:0] dv[4];
      logic [3:0] hi;
      logic [3:0] lo;
      sys_clk = 1'b0;
      rstn = 1'b0;
      req = '0;
      button_pressed = 1'b0;
      headset_present = 1'b0;
      failures = 0;
      samples_checked = 0;
      cycles = 0;
      rng_q = 32'd26;
      legal = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hf};
      dv = '{8'hb0, 8'h70, 8'h18, 8'h00};
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      #1;
      // Reset values at the ports and in the detection, gain and mixer registers.
      check("rst_mutes", {ctrl.left_mute, ctrl.right_mute}, 2'b11);
      check("rst_gains", {ctrl.left_gain, ctrl.right_gain}, 14'h0000);
      check("rst_mic", ctrl.mic, 20'h00000);
      check("rst_drv", {ctrl.ac_coupled, ctrl.full_diff, ctrl.pseudo_diff}, 3'b000);
      rd_check("detect_rst", DETECT_OFS, 8'h00);
      rd_check("lgain_rst", LGAIN_OFS, GAIN_RST);
      rd_check("rgain_rst", RGAIN_OFS, GAIN_RST);
      rd_check("micl_rst", MIC_L_OFS, MIX_RST);
      rd_check("micr_rst", MIC_R_OFS, MIX_RST);
      // An unmapped write is ignored and an unmapped read returns zero.
      wr_reg(8'h05, 8'h5a);
      rd_check("unmapped", 8'h05, 8'h00);
      // Driver bits take writes; status bits ignore them and reserved bits are written only as zeros. Both differential bits never go high together.
      foreach (dv[i]) begin
         wr_reg(DETECT_OFS, dv[i]);
         rd_check("detect_wr", DETECT_OFS, dv[i] & 8'hc8);
         settle();
         check("ac_coupled", ctrl.ac_coupled, dv[i][7]);
         check("full_diff", ctrl.full_diff, dv[i][6]);
         check("pseudo_diff", ctrl.pseudo_diff, dv[i][3]);
      end
      // Gain corners around saturation, then random settings.
      gain_case(1'b0, 8'h76);
      gain_case(1'b0, 8'h77);
      gain_case(1'b1, 8'h78);
      gain_case(1'b1, 8'h7f);
      gain_case(1'b0, 8'h80);
      for (int i = 0; i < 24; i++) begin
         gain_case(i[0], 8'(next_rand() >> 5));
      end
      // Write then read with no gap between the strobes.
      @(posedge sys_clk);
      req <= '{addr: LGAIN_OFS, wdata: 8'h2c, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      req <= '{addr: LGAIN_OFS, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      #1 check("b2b_read", rd_data, 8'h2c);
      // Every legal mixer code reaches every path; reserved codes are never written.
      for (int i = 0; i < 20; i++) begin
         hi = legal[(i < 10) ? i : next_rand() % 10];
         lo = legal[(i < 10) ? (i + 3) % 10 : next_rand() % 10];
         wr_reg(MIC_L_OFS, {hi, lo});
         wr_reg(MIC_R_OFS, {lo, hi});
         rd_check("micl_reg", MIC_L_OFS, {hi, lo});
         rd_check("micr_reg", MIC_R_OFS, {lo, hi});
         settle();
         check("mic_ll", ctrl.mic[0], route_exp(hi));
         check("mic_rl", ctrl.mic[1], route_exp(lo));
         check("mic_lr", ctrl.mic[2], route_exp(lo));
         check("mic_rr", ctrl.mic[3], route_exp(hi));
      end
      // A short press latches the flag; the interrupt stays low while masked.
      @(posedge sys_clk);
      button_pressed <= 1'b1;
      repeat (5) @(posedge sys_clk);
      button_pressed <= 1'b0;
      repeat (5) @(posedge sys_clk);
      #1 check("irq_masked", irq, 1'b0);
      rd_check("irq_stat_btn", IRQ_STAT_OFS, 8'h01);
      wr_reg(IRQ_MASK_OFS, 8'h01);
      settle();
      check("irq_on", irq, 1'b1);
      rd_check("detect_flag", DETECT_OFS, 8'h20);
      rd_check("detect_clr", DETECT_OFS, 8'h00);
      wr_reg(IRQ_STAT_OFS, 8'h01);
      settle();
      check("irq_off", irq, 1'b0);
      rd_check("irq_stat_clr", IRQ_STAT_OFS, 8'h00);
      // A press that meets a detection read in the same cycle is kept for the next read.
      @(posedge sys_clk);
      button_pressed <= 1'b1;
      repeat (2) @(posedge sys_clk);
      req <= '{addr: DETECT_OFS, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      button_pressed <= 1'b0;
      #1 check("detect_race", rd_data, 8'h00);
      rd_check("detect_kept", DETECT_OFS, 8'h20);
      check("irq_race", irq, 1'b1);
      wr_reg(IRQ_STAT_OFS, 8'h01);
      // The headset bit follows the pin live and a change raises its own status bit.
      @(posedge sys_clk);
      headset_present <= 1'b1;
      repeat (5) @(posedge sys_clk);
      rd_check("hs_on", DETECT_OFS, 8'h10);
      rd_check("hs_still", DETECT_OFS, 8'h10);
      rd_check("irq_stat_hs", IRQ_STAT_OFS, 8'h02);
      wr_reg(DETECT_OFS, 8'h30);
      rd_check("hs_ro", DETECT_OFS, 8'h10);
      wr_reg(IRQ_MASK_OFS, 8'h02);
      settle();
      check("irq_hs", irq, 1'b1);
      wr_reg(IRQ_STAT_OFS, 8'h02);
      settle();
      check("irq_hs_off", irq, 1'b0);
      @(posedge sys_clk);
      headset_present <= 1'b0;
      repeat (5) @(posedge sys_clk);
      rd_check("hs_off", DETECT_OFS, 8'h00);
      check("irq_unplug", irq, 1'b1);
      end_sim();
   end
endmodule // codec_adc_input_headset_regs_tb
